//--- rtl/bcvd_cfg.svh
`ifndef BCVD_CFG_SVH
`define BCVD_CFG_SVH

// Boot vector field positions
`define BCVD_F_PLL 3:0
`define BCVD_F_XDIV 5:4
`define BCVD_F_ENDIAN 6
`define BCVD_F_RMODE 7
`define BCVD_F_PCI 10:8
`define BCVD_F_WDT 11
`define BCVD_F_LOW_RSV 13:12
`define BCVD_F_HIGH_RSV 15:14

// Vector codes
`define BCVD_PLL_BYPASS 4'h0
`define BCVD_PLL_X3 4'h1
`define BCVD_PLL_X4 4'h2
`define BCVD_PLL_X5 4'h4
`define BCVD_PLL_X6 4'h6
`define BCVD_PLL_X8 4'h7
`define BCVD_PLL_X10 4'h8
`define BCVD_XDIV_RSV 2'h3
`define BCVD_PCI_SAT_NRDY 3'h1
`define BCVD_PCI_SAT_SUSP 3'h2
`define BCVD_PCI_LAST 3'h5

// Register byte offsets
`define BCVD_OFF_BVR 12'h000
`define BCVD_OFF_STAT 12'h004
`define BCVD_OFF_PCI_CTRL 12'h008

// Status and control bit positions
`define BCVD_STAT_RUN 0
`define BCVD_STAT_PLL_OK 1
`define BCVD_STAT_PLL_RSV 2
`define BCVD_STAT_XDIV_RSV 3
`define BCVD_STAT_PCI_RSV 4
`define BCVD_STAT_RMODE_RSV 5
`define BCVD_STAT_PIN_RSV 6
`define BCVD_PCI_CTRL_EN 0

// Reset values and counts
`define BCVD_VEC_RST 16'h0000
// Settings that the all-zero reset vector decodes to
`define BCVD_SET_RST '{1'b1, 4'h0, 2'h0, 1'b0, BCVD_PCI_DISABLED, 1'b1}
`define BCVD_RST_HOLD_CYC 13'h0fa0
`define BCVD_PLL_SETTLE_CYC 32'h0004_0000

`endif

//--- rtl/bcvd_pkg.sv
package bcvd_pkg;

    typedef enum logic [2:0] {
        BCVD_PCI_DISABLED,
        BCVD_PCI_SAT_NOT_READY,
        BCVD_PCI_SAT_SUSPENDED,
        BCVD_PCI_HOST_EXT_ARB,
        BCVD_PCI_HOST_FIXED_ARB,
        BCVD_PCI_HOST_RR_ARB,
        BCVD_PCI_RSV6,
        BCVD_PCI_RSV7
    } bcvd_pci_mode_e;

    // Decoded device-wide settings
    typedef struct packed {
        logic pll_bypass;
        logic [3:0] pll_mult;
        logic [1:0] xdiv_log2;
        logic big_endian;
        bcvd_pci_mode_e pci_mode;
        logic watchdog_enable;
    } bcvd_settings_s;

    // APB slave request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } bcvd_apb_req_s;

endpackage

//--- rtl/bcvd_clk_div.sv
`timescale 1ns/10ps
`default_nettype none

`include "bcvd_cfg.svh"

module bcvd_clk_div (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] div_sel,
    output logic internal_bus_clock,
    output logic external_clock_output
);
    logic bclk_r, bclk_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic xclk_r, xclk_nxt;

    // Bus clock is always half the pipeline rate; external clock divides it
    // clock dividers
    always_comb begin
        bclk_nxt = ~bclk_r;
        cnt_nxt = bclk_nxt ? cnt_r + 2'h1 : cnt_r;
        unique case (div_sel)
            2'h1: xclk_nxt = cnt_nxt[0];
            2'h2: xclk_nxt = cnt_nxt[1];
            default: xclk_nxt = bclk_nxt; // Reserved code falls back to divide by 1
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_r <= 1'b0;
            cnt_r <= 2'h0;
            xclk_r <= 1'b0;
        end else begin
            bclk_r <= bclk_nxt;
            cnt_r <= cnt_nxt;
            xclk_r <= xclk_nxt;
        end
    end

    assign internal_bus_clock = bclk_r;
    assign external_clock_output = xclk_r;

    // half rate bus clock; the first edge after reset has no history yet
    a_bus_clk_half: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> internal_bus_clock != $past(internal_bus_clock))
        else $error("bus clock did not toggle every pipeline cycle");

    // divide by four: high for four pipeline cycles while the code stands
    a_xclk_div_four: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(div_sel, 2) == 2'h2 && $stable(div_sel) && div_sel == 2'h2
        && $rose(external_clock_output) ##1 (div_sel == 2'h2) [*3])
        |=> $fell(external_clock_output))
        else $error("external clock divide by four period wrong");

endmodule // bcvd_clk_div

`default_nettype wire

//--- rtl/bcvd_top.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

`include "bcvd_cfg.svh"

// Overview of operation
// - Captured vector readable in boot vector register
// - Bits 3:0 pick PLL multiplier or bypass
// - Bits 5:4 divide bus clock for output
// - Bus clock always half pipeline clock
// - Bit 6 selects little or big endian
// - Normal mode holds reset output 4000 cycles
// - Internal vector waits 18-bit counter for PLL
// - Bits 10:8 pick PCI operating mode
// - PCI enable starts set for satellite modes
// - Bit 11 set leaves watchdog disabled
module bcvd_top #(
    parameter int PLL_SETTLE_CYCLES = `BCVD_PLL_SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire bcvd_pkg::bcvd_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cold_reset_n,
    input wire logic internal_vector_select,
    input wire logic [15:0] boot_vector_pins,
    output bcvd_pkg::bcvd_settings_s settings,
    output logic pci_enable,
    output logic pll_settled,
    output logic system_reset_output_n,
    output logic internal_bus_clock,
    output logic external_clock_output
);
    import bcvd_pkg::*;

    typedef enum logic [1:0] {
        ST_CAPTURE,
        ST_PLL_WAIT,
        ST_RST_HOLD,
        ST_RUN
    } bcvd_state_e;

    // Decode the multiplier code; zero means bypass or reserved
    function automatic logic [3:0] pll_mult_of(input logic [3:0] code);
        unique case (code)
            `BCVD_PLL_X3: pll_mult_of = 4'h3;
            `BCVD_PLL_X4: pll_mult_of = 4'h4;
            `BCVD_PLL_X5: pll_mult_of = 4'h5;
            `BCVD_PLL_X6: pll_mult_of = 4'h6;
            `BCVD_PLL_X8: pll_mult_of = 4'h8;
            `BCVD_PLL_X10: pll_mult_of = 4'ha;
            default: pll_mult_of = 4'h0;
        endcase
    endfunction

    // Address match for one register during a bus phase
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction

    // Two-stage synchronisers for pins
    logic cold_s1_r, cold_s2_r;
    logic sel_s1_r, sel_s2_r;
    logic [15:0] vec_s1_r, vec_s2_r;

    // First stages are read only by second stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cold_s1_r <= 1'b0;
            cold_s2_r <= 1'b0;
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
            vec_s1_r <= `BCVD_VEC_RST;
            vec_s2_r <= `BCVD_VEC_RST;
        end else begin
            cold_s1_r <= cold_reset_n;
            cold_s2_r <= cold_s1_r;
            sel_s1_r <= internal_vector_select;
            sel_s2_r <= sel_s1_r;
            vec_s1_r <= boot_vector_pins;
            vec_s2_r <= vec_s1_r;
        end
    end

    // Sequencer and captured vector
    bcvd_state_e state_r, state_nxt;
    logic [15:0] vec_r, vec_nxt;
    bcvd_settings_s set_r, set_nxt;
    logic [31:0] pll_cnt_r, pll_cnt_nxt;
    logic [12:0] hold_cnt_r, hold_cnt_nxt;
    logic pll_ok_r, pll_ok_nxt;
    logic capture_done;

    assign capture_done = (state_r == ST_CAPTURE) && cold_s2_r;

    always_comb begin
        state_nxt = state_r;
        vec_nxt = vec_r;
        pll_cnt_nxt = pll_cnt_r;
        hold_cnt_nxt = hold_cnt_r;
        pll_ok_nxt = pll_ok_r;
        unique case (state_r)
            ST_CAPTURE: begin
                if (!cold_s2_r) begin
                    vec_nxt = vec_s2_r;
                end else begin
                    state_nxt = sel_s2_r ? ST_PLL_WAIT : ST_RST_HOLD;
                    pll_ok_nxt = !sel_s2_r; // External vector has its own settling
                end
                pll_cnt_nxt = 32'h0;
                hold_cnt_nxt = 13'h0;
            end
            ST_PLL_WAIT: begin
                if (pll_cnt_r == PLL_SETTLE_CYCLES - 1) begin
                    state_nxt = ST_RST_HOLD;
                    pll_ok_nxt = 1'b1;
                end else begin
                    pll_cnt_nxt = pll_cnt_r + 32'h1;
                end
            end
            ST_RST_HOLD: begin
                if (hold_cnt_r == `BCVD_RST_HOLD_CYC - 13'h1) begin
                    state_nxt = ST_RUN;
                end else begin
                    hold_cnt_nxt = hold_cnt_r + 13'h1;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
        endcase
        // A new cold reset restarts capture from any state
        if (!cold_s2_r) begin
            state_nxt = ST_CAPTURE;
            vec_nxt = vec_s2_r;
            pll_ok_nxt = 1'b0;
        end
    end

    // Settings follow the vector so both flops agree every cycle
    always_comb begin
        set_nxt.pll_mult = pll_mult_of(vec_nxt[`BCVD_F_PLL]);
        set_nxt.pll_bypass = (set_nxt.pll_mult == 4'h0); // Reserved codes run unmultiplied
        set_nxt.xdiv_log2 = vec_nxt[`BCVD_F_XDIV];
        set_nxt.big_endian = vec_nxt[`BCVD_F_ENDIAN];
        set_nxt.pci_mode = bcvd_pci_mode_e'(vec_nxt[`BCVD_F_PCI]);
        set_nxt.watchdog_enable = ~vec_nxt[`BCVD_F_WDT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_CAPTURE;
            vec_r <= `BCVD_VEC_RST;
            set_r <= `BCVD_SET_RST; // Matches the decode of the reset vector
            pll_cnt_r <= 32'h0;
            hold_cnt_r <= 13'h0;
            pll_ok_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            vec_r <= vec_nxt;
            set_r <= set_nxt;
            pll_cnt_r <= pll_cnt_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            pll_ok_r <= pll_ok_nxt;
        end
    end

    // Reserved-code detectors, reported in status
    logic pll_rsv, xdiv_rsv, pci_rsv, pin_rsv;
    assign pll_rsv = set_r.pll_bypass && (vec_r[`BCVD_F_PLL] != `BCVD_PLL_BYPASS);
    assign xdiv_rsv = (vec_r[`BCVD_F_XDIV] == `BCVD_XDIV_RSV);
    assign pci_rsv = (vec_r[`BCVD_F_PCI] > `BCVD_PCI_LAST);
    assign pin_rsv = (vec_r[`BCVD_F_LOW_RSV] != 2'h0) || (vec_r[`BCVD_F_HIGH_RSV] != 2'h0);

    // APB slave: zero wait, read data prepared in the setup cycle
    logic [31:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic pci_en_r, pci_en_nxt;
    logic [31:0] stat_word;
    logic setup, wr_access;

    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;

    always_comb begin
        stat_word = 32'h0;
        stat_word[`BCVD_STAT_RUN] = (state_r == ST_RUN);
        stat_word[`BCVD_STAT_PLL_OK] = pll_ok_r;
        stat_word[`BCVD_STAT_PLL_RSV] = pll_rsv;
        stat_word[`BCVD_STAT_XDIV_RSV] = xdiv_rsv;
        stat_word[`BCVD_STAT_PCI_RSV] = pci_rsv;
        stat_word[`BCVD_STAT_RMODE_RSV] = vec_r[`BCVD_F_RMODE];
        stat_word[`BCVD_STAT_PIN_RSV] = pin_rsv;
    end

    always_comb begin
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        pci_en_nxt = pci_en_r;
        if (setup) begin
            err_nxt = !(hit(apb_req.paddr, `BCVD_OFF_BVR) || hit(apb_req.paddr, `BCVD_OFF_STAT)
                        || hit(apb_req.paddr, `BCVD_OFF_PCI_CTRL));
            rdata_nxt = 32'h0;
            if (!apb_req.pwrite) begin
                if (hit(apb_req.paddr, `BCVD_OFF_BVR)) begin
                    rdata_nxt = {16'h0, vec_r};
                end else if (hit(apb_req.paddr, `BCVD_OFF_STAT)) begin
                    rdata_nxt = stat_word;
                end else if (hit(apb_req.paddr, `BCVD_OFF_PCI_CTRL)) begin
                    rdata_nxt[`BCVD_PCI_CTRL_EN] = pci_en_r;
                end
            end
        end
        if (wr_access && hit(apb_req.paddr, `BCVD_OFF_PCI_CTRL)) begin
            pci_en_nxt = apb_req.pwdata[`BCVD_PCI_CTRL_EN];
        end
        if (state_r == ST_CAPTURE) begin
            pci_en_nxt = (vec_nxt[`BCVD_F_PCI] == `BCVD_PCI_SAT_NRDY)
                         || (vec_nxt[`BCVD_F_PCI] == `BCVD_PCI_SAT_SUSP);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0;
            err_r <= 1'b0;
            pci_en_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
            pci_en_r <= pci_en_nxt;
        end
    end

    assign prdata = rdata_r;
    assign pready = 1'b1; // Every access completes in one access cycle
    assign pslverr = apb_req.psel && apb_req.penable && err_r;
    assign settings = set_r;
    assign pci_enable = pci_en_r;
    assign pll_settled = pll_ok_r;
    assign system_reset_output_n = (state_r == ST_RUN);

    // Clock generation from the pipeline clock
    bcvd_clk_div u_clk_div (
        .pclk(pclk),
        .presetn(presetn),
        .div_sel(set_r.xdiv_log2),
        .internal_bus_clock(internal_bus_clock),
        .external_clock_output(external_clock_output)
    );

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_vector_frozen: assert property (
        (state_r != ST_CAPTURE && cold_s2_r) |=> $stable(vec_r))
        else $error("boot vector changed outside cold reset");

    a_reset_hold_len: assert property (
        $rose(system_reset_output_n) |-> $past(state_r) == ST_RST_HOLD
        && $past(hold_cnt_r) == `BCVD_RST_HOLD_CYC - 13'h1)
        else $error("reset output released before hold count");

    a_pll_wait_len: assert property (
        (state_r == ST_PLL_WAIT && state_nxt == ST_RST_HOLD)
        |-> pll_cnt_r == PLL_SETTLE_CYCLES - 1 && cold_s2_r)
        else $error("PLL wait ended early");

    a_pll_mult_map: assert property (
        (set_r.pll_mult == 4'ha) == (vec_r[`BCVD_F_PLL] == `BCVD_PLL_X10)
        && (set_r.pll_mult == 4'h5) == (vec_r[`BCVD_F_PLL] == `BCVD_PLL_X5))
        else $error("PLL multiplier decode wrong");

    a_endian_map: assert property (
        set_r.big_endian == vec_r[`BCVD_F_ENDIAN])
        else $error("endian setting disagrees with vector");

    a_watchdog_map: assert property (
        set_r.watchdog_enable != vec_r[`BCVD_F_WDT])
        else $error("watchdog setting disagrees with vector");

    a_pci_en_init: assert property (
        capture_done |=> pci_enable == (vec_r[`BCVD_F_PCI] == `BCVD_PCI_SAT_NRDY
        || vec_r[`BCVD_F_PCI] == `BCVD_PCI_SAT_SUSP))
        else $error("PCI enable initial value wrong");

    a_bvr_read_only: assert property (
        (wr_access && hit(apb_req.paddr, `BCVD_OFF_BVR) && state_r == ST_RUN && cold_s2_r)
        |=> $stable(vec_r) && !pslverr)
        else $error("boot vector register changed by a write");

    a_bvr_readback: assert property (
        (setup && !apb_req.pwrite && hit(apb_req.paddr, `BCVD_OFF_BVR))
        |=> prdata == {16'h0, $past(vec_r)} && pready)
        else $error("boot vector readback wrong");

    a_pci_mode_map: assert property (
        set_r.pci_mode == bcvd_pci_mode_e'(vec_r[`BCVD_F_PCI]))
        else $error("PCI mode disagrees with vector");

endmodule // bcvd_top

`default_nettype wire

//--- test/bcvd_strap_model.sv
`timescale 1ns/10ps
`default_nettype none

// Board side: straps the vector and paces the cold reset pin
module bcvd_strap_model (
    input wire logic pclk,
    input wire logic boot_hold_n,
    input wire logic [11:0] boot_code,
    output logic cold_reset_n,
    output logic [15:0] boot_vector_pins
);
    logic [3:0] cnt_r;

    initial begin
        cnt_r = 4'h0;
        cold_reset_n = 1'b0;
        boot_vector_pins = 16'h0000;
    end

    // Pins stay put 7 cycles after release; after that the bus is busy,
    // so the pins toggle every cycle rather than keep the strap value
    always @(posedge pclk) begin
        if (!boot_hold_n) begin
            cnt_r <= 4'h0;
            cold_reset_n <= 1'b0;
            boot_vector_pins <= {4'h0, boot_code};
        end else begin
            if (cnt_r != 4'hf) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (cnt_r == 4'h3) begin
                cold_reset_n <= 1'b1;
            end
            if (cnt_r >= 4'h7) begin
                boot_vector_pins <= ~boot_vector_pins;
            end
        end
    end
endmodule // bcvd_strap_model

`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected t=%0t got %0h exp %0h", $time, (g), (e)); end end

module tb_top;
    import bcvd_pkg::*;
    logic pclk, presetn, hold_n, ivsel, coldn, err, b, prev;
    logic pready, pslverr, pci_enable, pll_settled, rst_out_n, ibclk, ext_clk;
    logic [11:0] code, v;
    logic [15:0] pins;
    logic [31:0] rd, prdata;
    bcvd_apb_req_s apb_req;
    bcvd_settings_s settings;
    int n_errors, n_checks, cyc, n, m, p;

    bcvd_strap_model board (.pclk(pclk), .boot_hold_n(hold_n), .boot_code(code),
        .cold_reset_n(coldn), .boot_vector_pins(pins));

    bcvd_top #(.PLL_SETTLE_CYCLES(16)) dut (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cold_reset_n(coldn), .internal_vector_select(ivsel), .boot_vector_pins(pins),
        .settings(settings), .pci_enable(pci_enable), .pll_settled(pll_settled),
        .system_reset_output_n(rst_out_n), .internal_bus_clock(ibclk),
        .external_clock_output(ext_clk));

    // Clock at 20 MHz
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Hang guard: four boots of about 4000 cycles each fit well inside
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One APB transfer; an idle edge follows so the bus is never driven twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // Access lasts until the slave answers; only the hang guard ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
        @(posedge pclk);
    endtask

    // Decoded settings expected for a vector
    function automatic bcvd_settings_s exp_set(input logic [15:0] x);
        bcvd_settings_s s;
        logic [3:0] mul;
        case (x[3:0])
            4'h1: mul = 4'h3;
            4'h2: mul = 4'h4;
            4'h4: mul = 4'h5;
            4'h6: mul = 4'h6;
            4'h7: mul = 4'h8;
            4'h8: mul = 4'ha;
            default: mul = 4'h0;
        endcase
        s.pll_bypass = (mul == 4'h0);
        s.pll_mult = mul;
        s.xdiv_log2 = x[5:4];
        s.big_endian = x[6];
        s.pci_mode = bcvd_pci_mode_e'(x[10:8]);
        s.watchdog_enable = ~x[11];
        return s;
    endfunction

    // Status word expected once a boot has finished: running and settled
    function automatic logic [31:0] exp_stat(input logic [15:0] x);
        bcvd_settings_s s;
        s = exp_set(x);
        exp_stat = {25'h0, x[15:12] != 4'h0, x[7], x[10:8] > 3'h5, x[5:4] == 2'h3,
            s.pll_bypass && x[3:0] != 4'h0, 2'h3};
    endfunction

    // Main sequence
    initial begin
        presetn = 1'b0;
        hold_n = 1'b0;
        ivsel = 1'b0;
        code = 12'h000;
        apb_req = '0;
        void'($urandom(32'h532c));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(rst_out_n, 1'b0)
        #1 b = ibclk;
        repeat (8) begin
            @(posedge pclk);
            #1 `CHK(ibclk, ~b)
            b = ibclk;
        end
        @(posedge pclk);
        $display("test bus clock done");
        // Sweep codes while cold reset is held; every pll, pci and divider code
        for (int k = 0; k < 48; k++) begin
            v = 12'($urandom()) & 12'hf7f;
            if (k < 16) v[3:0] = 4'(k);
            if (k < 8) v[10:8] = 3'(k);
            if (k < 4) v[5:4] = 2'(k);
            code <= v;
            repeat (6) @(posedge pclk);
            `CHK(settings, exp_set({4'h0, v}))
        end
        $display("test decode sweep done");
        for (int i = 0; i < 4; i++) begin
            v = 12'($urandom()) & 12'h84f;
            v[5:4] = 2'(i);
            v[10:8] = 3'((5 - i) % 4);
            code <= v;
            ivsel <= i[0];
            hold_n <= 1'b0;
            repeat (8) @(posedge pclk);
            hold_n <= 1'b1;
            n = 0;
            while (coldn !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
            n = 0;
            while (rst_out_n !== 1'b1 && n < 9000) begin @(posedge pclk); n++; end
            `CHK(n >= 4000 + 16 * i[0] && n < 4040 + 16 * i[0], 1'b1)
            `CHK(pll_settled, 1'b1)
            `CHK(pci_enable, v[10:8] == 3'h1 || v[10:8] == 3'h2)
            apb(1'b0, 12'h000, 32'h0);
            `CHK(rd, {20'h0, v})
            apb(1'b1, 12'h000, 32'hffffffff);
            apb(1'b0, 12'h000, 32'h0);
            `CHK(rd, {20'h0, v})
            apb(1'b0, 12'h004, 32'h0);
            `CHK(rd, exp_stat({4'h0, v}))
            apb(1'b0, 12'h00c, 32'h0);
            `CHK({err, rd}, 33'h100000000)
            apb(1'b1, 12'h008, 32'h1);
            `CHK(pci_enable, 1'b1)
            // Period between two rising edges of the external clock
            m = 0;
            p = 0;
            n = 0;
            prev = ext_clk;
            while (p < 2 && n < 40) begin
                @(posedge pclk);
                n++;
                if (ext_clk === 1'b1 && prev === 1'b0) begin p++; if (p == 1) m = n; end
                prev = ext_clk;
            end
            `CHK(n - m, (i == 3) ? 2 : (2 << i))
            `CHK(settings, exp_set({4'h0, v}))
            $display("test boot %0d done", i);
        end
        finish_test();
    end
endmodule // tb_top

`default_nettype wire
